/* rtl/umd_pkg.sv */
/*
  umd_pkg: constants, field layouts and shared types of the multidrop uart.
  assumes one 25 MHz system clock and a synchronous active-high reset.
*/
package umd_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int CTS_LEAD_NS = 40;
  localparam int CTS_LEAD_CYC = (CTS_LEAD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  // ----------------------------------------------------------------
  // multidrop filter modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MD_ALL_ADDR = 2'h1;
  localparam logic [1:0] MD_HW_MATCH = 2'h2;
  localparam logic [1:0] MD_HW_DATA = 2'h3;
  localparam int MD_BIT_ADDR_ONLY = 0;
  localparam logic POL_ACTIVE_HIGH = 1'b0;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } umd_word_t;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic perr;
    logic ferr;
    logic brk;
  } umd_rxword_t;

  typedef struct packed {
    logic rx_byte_available;
    logic parity_err;
    logic overrun_err;
    logic framing_err;
    logic break_seen;
    logic tx_holding_empty;
    logic tx_shift_empty;
    logic new_frame_flag;
    logic rx_ninth_bit;
  } umd_status_t;
endpackage : umd_pkg

/* rtl/umd_buf2.sv */
/*
  umd_buf2: two-entry valid/ready buffer for transmit words.
  assumes both sides run on clk_sys.
*/
`timescale 1ns/1ps
module umd_buf2 (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire umd_pkg::umd_word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output umd_pkg::umd_word_t out_word
);
  import umd_pkg::*;
  umd_word_t mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_word = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= in_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : umd_buf2

/* rtl/umd_sync3.sv */
/*
  umd_sync3: three-flop input synchroniser with agreement filter.
  assumes an asynchronous pin input; reset value is given by parameter.
*/
`timescale 1ns/1ps
module umd_sync3 #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      level <= INIT;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // change accepted once the two later stages agree
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule : umd_sync3

/* rtl/umd_uart.sv */
/*
  umd_uart: uart with cts flow control, 9-bit multidrop filtering and a
  transceiver driver enable. holds the tx and rx engines and status.
  assumes control bits are steady while the uart is enabled.
*/
//
// Overview of operation
// [R1] cts sampled one clock before each character
// [R2] remote drops cts before next character starts
// [R3] cts drop mid-character finishes that character
// [R4] ninth bit follows data, precedes stop
// [R5] multidrop replaces parity with ninth bit
// [R6] filtering only while multidrop enabled
// [R7] mode 01 interrupts on address bytes only
// [R8] clearing mode bit0 interrupts every byte
// [R9] rx ninth bit status holds last ninth
// [R10] mode 10 drops unmatched address frames
// [R11] matched address interrupts, first data flagged
// [R12] later addresses recompared, mismatch ignores frame
// [R13] mode 11 as 10, no address interrupts
// [R14] driver enable spans whole frame from write
// [R15] driver enable leads start by 1-2 bits
// [R16] driver enable drops one clock after stop
// [R17] back-to-back writes keep driver enable on
// [R18] polarity bit selects driver enable sense
// [R19] holding empty set after first bit sent
// [R20] rx interrupt on data, break, overrun, framing
// [R21] overrun keeps byte, hides error until read
// [R22] second read clears errors after overrun
// [R23] start, 8 data lsb first, opt bit, stops
// [R24] bit rate is clock over 16 times divisor
// [R25] data read clears rx status indications
// [R26] sender sets ninth bit per byte kind
// [R27] reset: holding empty set, driver enable off; code drives the pin low at reset, which is on when polarity is 1
`timescale 1ns/1ps
module umd_uart (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] baud_divisor,
  input wire logic tx_enable_bit,
  input wire logic rx_enable_bit,
  input wire logic flow_ctrl_enable,
  input wire logic parity_enable,
  input wire logic parity_odd,
  input wire logic two_stop_bits,
  input wire logic multidrop_enable,
  input wire logic [1:0] multidrop_filter_mode,
  input wire logic [7:0] address_compare,
  input wire logic drive_enable_polarity,
  input wire logic rx_data_irq_enable,
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  input wire logic tx_ninth_bit,
  input wire logic rx_read,
  input wire logic cts_n_pin,
  input wire logic rxd_pin,
  output logic txd,
  output logic xcvr_drive_enable,
  output logic [7:0] rx_data,
  output umd_pkg::umd_status_t status,
  output logic tx_irq,
  output logic rx_irq
);
  import umd_pkg::*;

  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction : par_of

  // ----------------------------------------------------------------
  // baud tick, 16x oversampling
  // ----------------------------------------------------------------
  logic [15:0] div_cnt_r;
  logic tick;
  // [R24] divide by divisor
  always_ff @(posedge clk_sys) begin
    if (rst || (!tx_enable_bit && !rx_enable_bit)) begin
      div_cnt_r <= DIV_RESET;
    end else if (div_cnt_r >= baud_divisor) begin
      div_cnt_r <= DIV_RESET;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end
  assign tick = (div_cnt_r >= baud_divisor);

  logic cts_n;
  logic rxd_s;
  umd_sync3 #(.INIT(1'b1)) u_cts (.clk_sys(clk_sys), .rst(rst), .pin(cts_n_pin), .level(cts_n));
  umd_sync3 #(.INIT(1'b1)) u_rxd (.clk_sys(clk_sys), .rst(rst), .pin(rxd_pin), .level(rxd_s));

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  umd_word_t wr_word;
  umd_word_t hold_word;
  logic hold_valid;
  logic hold_ready;
  logic buf_in_ready;
  logic hold_nxt_empty;
  assign wr_word = '{data: tx_data, ninth: tx_ninth_bit};
  umd_buf2 u_buf (
    .clk_sys(clk_sys), .rst(rst), .in_valid(tx_write), .in_ready(buf_in_ready),
    .in_word(wr_word), .out_valid(hold_valid), .out_ready(hold_ready), .out_word(hold_word)
  );

  typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_NINTH, TX_STOP} umd_tx_t;
  umd_tx_t tx_st_r;
  logic [3:0] tx_ovs_r;
  logic [2:0] tx_bit_r;
  logic [8:0] tx_sh_r;
  logic tx_stop2_r;
  logic tx_bit_end;
  logic tx_last_stop;
  logic cts_ok;
  logic tx_holding_empty_r;
  logic de_active_r;

  assign tx_bit_end = tick && (tx_ovs_r == OVS_LAST);
  assign tx_last_stop = (tx_st_r == TX_STOP) && tx_bit_end && (tx_stop2_r || !two_stop_bits);
  // [R1] sampled in the cycle before start
  assign cts_ok = !flow_ctrl_enable || !cts_n;
  assign hold_ready = (tx_st_r == TX_LEAD) && tx_bit_end && cts_ok;
  assign hold_nxt_empty = !hold_valid;

  always_ff @(posedge clk_sys) begin
    if (rst || !tx_enable_bit) begin
      tx_st_r <= TX_IDLE;
      tx_ovs_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 9'h000;
      tx_stop2_r <= 1'b0;
    end else begin
      if (tick) begin
        tx_ovs_r <= tx_ovs_r + 4'h1;
      end
      case (tx_st_r)
        // [R15] one full bit of lead time
        TX_IDLE: begin
          if (hold_valid) begin
            tx_st_r <= TX_LEAD;
            tx_ovs_r <= 4'h0;
          end
        end
        TX_LEAD: begin
          // [R3] held only between characters
          if (hold_ready) begin
            tx_st_r <= TX_START;
            tx_sh_r <= {hold_word.ninth, hold_word.data};
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_st_r <= TX_DATA;
            tx_bit_r <= 3'h0;
          end
        end
        // [R23] lsb first
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == 3'h7) begin
              tx_st_r <= (multidrop_enable || parity_enable) ? TX_NINTH : TX_STOP;
              tx_stop2_r <= 1'b0;
            end
          end
        end
        TX_NINTH: begin
          if (tx_bit_end) begin
            tx_st_r <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            tx_stop2_r <= 1'b1;
            // [R17] queued byte keeps drive on
            if (tx_last_stop) begin
              tx_st_r <= hold_valid ? TX_LEAD : TX_IDLE;
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txd <= 1'b1;
    end else begin
      case (tx_st_r)
        TX_START: txd <= 1'b0;
        TX_DATA: txd <= tx_sh_r[tx_bit_r];
        // [R4] [R5] ninth bit replaces parity
        TX_NINTH: txd <= multidrop_enable ? tx_sh_r[8] : par_of(tx_sh_r[7:0], parity_odd);
        default: txd <= 1'b1;
      endcase
    end
  end

  // [R19] set after start bit shifted; [R27] set at reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_holding_empty_r <= 1'b1;
    end else if (tx_write) begin
      tx_holding_empty_r <= 1'b0;
    end else if (tx_st_r == TX_START && tx_bit_end && hold_nxt_empty) begin
      tx_holding_empty_r <= 1'b1;
    end else if (tx_st_r == TX_IDLE && hold_nxt_empty) begin
      tx_holding_empty_r <= 1'b1;
    end
  end

  // [R14] [R16] write to one clock after last stop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      de_active_r <= 1'b0;
    end else if (tx_write && buf_in_ready && tx_enable_bit) begin
      de_active_r <= 1'b1;
    end else if (tx_st_r == TX_IDLE && !hold_valid) begin
      de_active_r <= 1'b0;
    end
  end

  // [R18] polarity select
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xcvr_drive_enable <= POL_ACTIVE_HIGH;
    end else begin
      xcvr_drive_enable <= de_active_r ^ drive_enable_polarity;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= tx_holding_empty_r && tx_enable_bit;
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} umd_rx_t;
  umd_rx_t rx_st_r;
  logic [3:0] rx_ovs_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_ninth_r;
  logic rx_done;
  logic rx_mid;
  umd_rxword_t rx_word;
  assign rx_mid = tick && (rx_ovs_r == OVS_MID);

  always_ff @(posedge clk_sys) begin
    if (rst || !rx_enable_bit) begin
      rx_st_r <= RX_IDLE;
      rx_ovs_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_ninth_r <= 1'b0;
    end else begin
      if (tick) begin
        rx_ovs_r <= rx_ovs_r + 4'h1;
      end
      case (rx_st_r)
        RX_IDLE: begin
          if (!rxd_s) begin
            rx_st_r <= RX_START;
            rx_ovs_r <= 4'h0;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            rx_st_r <= rxd_s ? RX_IDLE : RX_DATA;
            rx_bit_r <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == 3'h7) begin
              rx_st_r <= (multidrop_enable || parity_enable) ? RX_NINTH : RX_STOP;
              rx_ninth_r <= 1'b0;
            end
          end
        end
        RX_NINTH: begin
          if (rx_mid) begin
            rx_ninth_r <= rxd_s;
            rx_st_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_st_r <= RX_IDLE;
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end
  assign rx_done = (rx_st_r == RX_STOP) && rx_mid;
  assign rx_word = '{data: rx_sh_r, ninth: rx_ninth_r,
    perr: parity_enable && !multidrop_enable && (rx_ninth_r != par_of(rx_sh_r, parity_odd)),
    ferr: !rxd_s,
    brk: !rxd_s && (rx_sh_r == 8'h00) && !rx_ninth_r};

  // ----------------------------------------------------------------
  // multidrop filter
  // ----------------------------------------------------------------
  logic md_accept_r;
  logic md_first_r;
  logic is_addr;
  logic addr_match;
  logic keep_byte;
  logic irq_byte;
  assign is_addr = rx_word.ninth;
  assign addr_match = (rx_word.data == address_compare);

  // [R6] [R10] [R12] frame acceptance
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      md_accept_r <= 1'b0;
      md_first_r <= 1'b0;
    end else if (rx_done && multidrop_enable && multidrop_filter_mode[1] && is_addr) begin
      md_accept_r <= addr_match;
      md_first_r <= addr_match;
    end else if (rx_done && keep_byte && !is_addr) begin
      md_first_r <= 1'b0;
    end
  end

  always_comb begin
    keep_byte = 1'b1;
    irq_byte = 1'b1;
    if (multidrop_enable) begin
      case (multidrop_filter_mode)
        // [R7] [R8] address only while bit0 set
        MD_ALL_ADDR: irq_byte = is_addr || !multidrop_filter_mode[MD_BIT_ADDR_ONLY];
        // [R11]
        MD_HW_MATCH: begin
          keep_byte = is_addr ? addr_match : md_accept_r;
          irq_byte = keep_byte;
        end
        // [R13] address bytes silent
        MD_HW_DATA: begin
          keep_byte = is_addr ? 1'b0 : md_accept_r;
          irq_byte = keep_byte;
        end
        default: irq_byte = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive data and status
  // ----------------------------------------------------------------
  logic rda_r;
  logic perr_r;
  logic ferr_r;
  logic ovr_pend_r;
  logic brk_pend_r;
  logic ovr_r;
  logic brk_r;
  logic nf_r;
  logic ninth_r;
  logic rx_irq_src_r;
  logic take;
  assign take = rx_done && keep_byte;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_data <= 8'h00;
      rda_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      nf_r <= 1'b0;
      ninth_r <= 1'b0;
      ovr_pend_r <= 1'b0;
      brk_pend_r <= 1'b0;
      ovr_r <= 1'b0;
      brk_r <= 1'b0;
      rx_irq_src_r <= 1'b0;
    end else if (take && rda_r) begin
      // [R21] keep unread byte, hold errors back
      ovr_pend_r <= 1'b1;
      brk_pend_r <= brk_pend_r || rx_word.brk;
    end else if (take) begin
      // set wins over a same-cycle read
      rx_data <= rx_word.data;
      rda_r <= 1'b1;
      perr_r <= rx_word.perr;
      ferr_r <= rx_word.ferr;
      brk_r <= rx_word.brk;
      // [R9] last ninth bit
      ninth_r <= rx_word.ninth;
      nf_r <= multidrop_enable && md_first_r && !is_addr && multidrop_filter_mode[1];
      rx_irq_src_r <= irq_byte;
    end else if (rx_read) begin
      // [R22] reveal errors, keep rda for second read
      if (ovr_pend_r) begin
        ovr_r <= 1'b1;
        brk_r <= brk_pend_r;
        ovr_pend_r <= 1'b0;
        brk_pend_r <= 1'b0;
      end else begin
        // [R25] read clears indications
        rda_r <= 1'b0;
        ovr_r <= 1'b0;
        brk_r <= 1'b0;
        rx_irq_src_r <= 1'b0;
      end
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      nf_r <= 1'b0;
      ninth_r <= 1'b0;
    end
  end

  // [R20] data maskable, overrun, framing and break always
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= (rda_r && rx_irq_src_r && rx_data_irq_enable) || ovr_r || ferr_r || brk_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= '{tx_holding_empty: 1'b1, tx_shift_empty: 1'b1, default: 1'b0};
    end else begin
      status <= '{rx_byte_available: rda_r, parity_err: perr_r, overrun_err: ovr_r,
        framing_err: ferr_r, break_seen: brk_r, tx_holding_empty: tx_holding_empty_r,
        tx_shift_empty: (tx_st_r == TX_IDLE) || (tx_st_r == TX_LEAD),
        new_frame_flag: nf_r, rx_ninth_bit: ninth_r};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_cts_hold;
    @(posedge clk_sys) disable iff (rst)
      (tx_st_r == TX_LEAD && flow_ctrl_enable && cts_n) |=> (tx_st_r != TX_START);
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("start while cts off"); // [R1]

  property p_no_abort;
    @(posedge clk_sys) disable iff (rst || !tx_enable_bit)
      (tx_st_r == TX_DATA) |=> (tx_st_r inside {TX_DATA, TX_NINTH, TX_STOP});
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("character cut short"); // [R3]

  property p_de_start;
    @(posedge clk_sys) disable iff (rst)
      (tx_st_r == TX_START) |-> (de_active_r && (xcvr_drive_enable != drive_enable_polarity));
  endproperty
  a_de_start: assert property (p_de_start) else $error("start without drive enable"); // [R14]

  property p_de_pol;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> (xcvr_drive_enable == ($past(de_active_r) ^ $past(drive_enable_polarity)));
  endproperty
  a_de_pol: assert property (p_de_pol) else $error("drive enable polarity wrong"); // [R18]

  property p_start_low;
    @(posedge clk_sys) disable iff (rst)
      (tx_st_r == TX_START) |=> !txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // [R23]

  property p_wr_clears;
    @(posedge clk_sys) disable iff (rst)
      tx_write |=> !tx_holding_empty_r;
  endproperty
  a_wr_clears: assert property (p_wr_clears) else $error("write left empty set"); // [R19]

  property p_ovr_keep;
    @(posedge clk_sys) disable iff (rst)
      (take && rda_r) |=> ($stable(rx_data) && $stable(ovr_r));
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("overrun overwrote data"); // [R21]

  property p_md11_silent;
    @(posedge clk_sys) disable iff (rst)
      (rx_done && multidrop_enable && multidrop_filter_mode == MD_HW_DATA && is_addr)
        |=> !(rda_r && !$past(rda_r));
  endproperty
  a_md11_silent: assert property (p_md11_silent) else $error("address byte kept"); // [R13]

  c_md_match: cover property (@(posedge clk_sys) nf_r);
  c_overrun: cover property (@(posedge clk_sys) ovr_r);
  c_cts_wait: cover property (@(posedge clk_sys) tx_st_r == TX_LEAD && cts_n && flow_ctrl_enable);
endmodule : umd_uart

/* dv/umd_node_model.sv */
/*
  umd_node_model: remote serial node on the far side of the uart.
  assumes divisor 1 (16 clocks a bit) and an idle-high line.
*/
`timescale 1ns/1ps
module umd_node_model (
  input wire logic clk_sys,
  input wire logic txd,
  input wire logic hold_off,
  output logic cts_n_pin,
  output logic rxd_pin
);
  logic [9:0] got_q[$];
  logic [9:0] sh;
  assign cts_n_pin = hold_off;
  initial rxd_pin = 1'b1;
  // ----------------------------------------------------------------
  // sender, caller starts at a falling edge
  // ----------------------------------------------------------------
  // start, lsb first, ninth, stop
  task automatic send_char(input logic [7:0] d, input logic n, input logic stp);
    logic [10:0] f;
    f = {stp, n, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_pin = f[i];
      repeat (16) @(negedge clk_sys);
    end
    rxd_pin = 1'b1;
  endtask : send_char
  // mid-bit sampling keeps clear of the registered txd edges
  always begin
    @(negedge txd);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      repeat (16) @(posedge clk_sys);
      sh[i] = txd;
    end
    got_q.push_back(sh);
  end
endmodule : umd_node_model

/* dv/tb_umd_uart.sv */
/*
  tb_umd_uart: self-checking bench for the multidrop uart.
  assumes umd_node_model on the serial side and a baud divisor of 1.
*/
`timescale 1ns/1ps
module tb_umd_uart;
  import umd_pkg::*;
  typedef struct packed {
    logic [1:0] md;
    logic [7:0] d;
    logic n;
    logic irq;
    logic nf;
  } umd_row_t;
  localparam umd_row_t ROWS [12] = '{'{2'h2, 8'h33, 1'b1, 1'b0, 1'b0},
    '{2'h2, 8'h11, 1'b0, 1'b0, 1'b0}, '{2'h2, 8'h5a, 1'b1, 1'b1, 1'b0},
    '{2'h2, 8'h77, 1'b0, 1'b1, 1'b1}, '{2'h2, 8'h78, 1'b0, 1'b1, 1'b0},
    '{2'h2, 8'h12, 1'b1, 1'b0, 1'b0}, '{2'h2, 8'h13, 1'b0, 1'b0, 1'b0},
    '{2'h3, 8'h5a, 1'b1, 1'b0, 1'b0}, '{2'h3, 8'h99, 1'b0, 1'b1, 1'b1},
    '{2'h1, 8'h44, 1'b1, 1'b1, 1'b0}, '{2'h1, 8'h45, 1'b0, 1'b0, 1'b0},
    '{2'h0, 8'h46, 1'b0, 1'b1, 1'b0}};
  logic clk_sys = 1'b0, rst = 1'b1, tx_en = 1'b0, rx_en = 1'b0, flow = 1'b0;
  logic md_en = 1'b1, pol = 1'b0, irq_en = 1'b1, tx_write = 1'b0, tx_ninth = 1'b0;
  logic rx_read = 1'b0, hold_off = 1'b0, par = 1'b0;
  logic [1:0] md = 2'h0;
  logic [7:0] tx_data = 8'h00;
  logic cts_n_pin, rxd_pin, txd, de, tx_irq, rx_irq;
  logic [7:0] rx_data;
  umd_status_t status;
  int checks = 0, miscompares = 0, cyc = 0, n, g;
  always #20 clk_sys = ~clk_sys;
  umd_uart u_umd_uart (.clk_sys(clk_sys), .rst(rst), .baud_divisor(16'h0001),
    .tx_enable_bit(tx_en), .rx_enable_bit(rx_en), .flow_ctrl_enable(flow),
    .parity_enable(par), .parity_odd(1'b0), .two_stop_bits(1'b0),
    .multidrop_enable(md_en), .multidrop_filter_mode(md), .address_compare(8'h5a),
    .drive_enable_polarity(pol), .rx_data_irq_enable(irq_en), .tx_write(tx_write),
    .tx_data(tx_data), .tx_ninth_bit(tx_ninth), .rx_read(rx_read),
    .cts_n_pin(cts_n_pin), .rxd_pin(rxd_pin), .txd(txd), .xcvr_drive_enable(de),
    .rx_data(rx_data), .status(status), .tx_irq(tx_irq), .rx_irq(rx_irq));
  umd_node_model u_umd_node_model (.clk_sys(clk_sys), .txd(txd), .hold_off(hold_off),
    .cts_n_pin(cts_n_pin), .rxd_pin(rxd_pin));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic put_tx(input logic [7:0] d, input logic nb);
    tx_write = 1'b1;
    tx_data = d;
    tx_ninth = nb;
    @(negedge clk_sys);
    tx_write = 1'b0;
    @(negedge clk_sys);
  endtask : put_tx
  task automatic pulse_read();
    rx_read = 1'b1;
    @(negedge clk_sys);
    rx_read = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse_read
  // counts cycles with the driver off while frames arrive
  task automatic wait_frames(input int k, output int gaps);
    int t;
    t = 0;
    gaps = 0;
    while (u_umd_node_model.got_q.size() < k && t < 3000) begin
      @(negedge clk_sys);
      t++;
      gaps += (de !== 1'b1);
    end
  endtask : wait_frames
  task automatic chk_frame(input logic [7:0] d, input logic nb);
    logic [9:0] f;
    f = 10'h000;
    if (u_umd_node_model.got_q.size() > 0) f = u_umd_node_model.got_q.pop_front();
    chk("txd frame", {1'b1, nb, d}, f);
  endtask : chk_frame
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk_sys);
    chk("tx_holding_empty", 1, status.tx_holding_empty);
    chk("drive enable", 0, de);
    chk("txd idle", 1, txd);
    rst = 1'b0;
    tx_en = 1'b1;
    rx_en = 1'b1;
    @(negedge clk_sys);
    $display("test reset done");
    foreach (ROWS[i]) begin
      md = ROWS[i].md;
      u_umd_node_model.send_char(ROWS[i].d, ROWS[i].n, 1'b1);
      repeat (4) @(negedge clk_sys);
      chk("rx_irq", ROWS[i].irq, rx_irq);
      if (ROWS[i].irq) begin
        chk("rx_data", ROWS[i].d, rx_data);
        chk("new_frame_flag", ROWS[i].nf, status.new_frame_flag);
        chk("rx_ninth_bit", ROWS[i].n, status.rx_ninth_bit);
      end
      pulse_read();
      chk("rx_byte_available", 0, status.rx_byte_available);
    end
    $display("test filter rows done");
    put_tx(8'ha5, 1'b1);
    n = 0;
    while (txd === 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n += (de === 1'b1);
      if (n == 4) chk("tx_holding_empty", 0, status.tx_holding_empty);
    end
    chk("de lead", 1, n >= 16 && n <= 32);
    repeat (40) @(negedge clk_sys);
    chk("tx_irq", 1, tx_irq && status.tx_holding_empty);
    chk("tx_shift_empty", 0, status.tx_shift_empty);
    wait_frames(1, g);
    chk_frame(8'ha5, 1'b1);
    n = 0;
    while (de === 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("de tail", 1, n >= 6 && n <= 12);
    $display("test single frame done");
    put_tx(8'h3c, 1'b0);
    put_tx(8'hc3, 1'b1);
    wait_frames(2, g);
    chk("de gaps", 0, g);
    chk_frame(8'h3c, 1'b0);
    chk_frame(8'hc3, 1'b1);
    $display("test back to back done");
    flow = 1'b1;
    hold_off = 1'b1;
    put_tx(8'h96, 1'b1);
    n = 0;
    repeat (100) begin
      @(negedge clk_sys);
      n += (txd !== 1'b1);
    end
    chk("txd held", 0, n);
    hold_off = 1'b0;
    n = 0;
    while (txd === 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (40) @(negedge clk_sys);
    hold_off = 1'b1;
    wait_frames(1, g);
    chk_frame(8'h96, 1'b1);
    hold_off = 1'b0;
    flow = 1'b0;
    repeat (40) @(negedge clk_sys);
    pol = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("de inverted idle", 1, de);
    pol = 1'b0;
    $display("test flow and polarity done");
    md_en = 1'b0;
    irq_en = 1'b0;
    u_umd_node_model.send_char(8'h00, 1'b0, 1'b1);
    repeat (4) @(negedge clk_sys);
    chk("framing_err", 1, status.framing_err);
    chk("break_seen", 1, status.break_seen);
    chk("rx_irq on error", 1, rx_irq);
    pulse_read();
    chk("framing_err", 0, status.framing_err);
    u_umd_node_model.send_char(8'h21, 1'b1, 1'b1);
    repeat (4) @(negedge clk_sys);
    chk("rx_irq masked", 0, rx_irq);
    irq_en = 1'b1;
    u_umd_node_model.send_char(8'h22, 1'b1, 1'b1);
    repeat (4) @(negedge clk_sys);
    chk("rx_data kept", 8'h21, rx_data);
    chk("overrun hidden", 0, status.overrun_err);
    pulse_read();
    chk("overrun shown", 1, status.overrun_err && status.rx_byte_available);
    pulse_read();
    chk("overrun cleared", 0, status.overrun_err);
    par = 1'b1;
    put_tx(8'h07, 1'b0);
    wait_frames(1, g);
    chk_frame(8'h07, 1'b1);
    u_umd_node_model.send_char(8'h07, 1'b0, 1'b1);
    repeat (4) @(negedge clk_sys);
    chk("parity_err", 1, status.parity_err);
    pulse_read();
    par = 1'b0;
    $display("test errors done");
    put_tx(8'h55, 1'b0);
    repeat (30) @(negedge clk_sys);
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk("tx_holding_empty", 1, status.tx_holding_empty);
    chk("drive enable", 0, de);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule : tb_umd_uart
